//--- core/xlat_pkg.sv
// Constants for the bus adapter address translation block
package xlat_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] UTIL_OFS = 8'h00;
  localparam logic [7:0] NODE_OFS = 8'h04;
  localparam logic [7:0] OT_IDX_OFS = 8'h08;
  localparam logic [7:0] OT_DATA_OFS = 8'h0c;
  localparam logic [7:0] PM_IDX_OFS = 8'h10;
  localparam logic [7:0] PM_DATA_OFS = 8'h14;
  localparam logic [7:0] ECC_INJ_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1c;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int MODE_LSB = 17;
  localparam int NODE_LSB = 25;
  localparam int OT_SEL_LSB = 20;
  localparam int ENTRY_VALID_BIT = 31;
  localparam int CE_CNT_LSB = 8;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [6:0] NODE_RESET = 7'h00;
  // ****************************************
  // Mapping modes
  // ****************************************
  localparam logic [2:0] MODE_PASS = 3'h0;
  localparam logic [2:0] MODE_P34 = 3'h1;
  localparam logic [2:0] MODE_P40_512 = 3'h2;
  localparam logic [2:0] MODE_P40_4K = 3'h3;
  localparam logic [2:0] MODE_P40_8K = 3'h4;
  // ****************************************
  // Abort causes
  // ****************************************
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_RANGE = 2'h1;
  localparam logic [1:0] CAUSE_INVALID = 2'h2;
  localparam logic [1:0] CAUSE_ECC = 2'h3;
  // ****************************************
  // Table geometry
  // ****************************************
  localparam int OT_DEPTH = 32;
  localparam int OT_W = 16;
  localparam int PM_DEPTH = 65536;
  localparam int PM_W = 39;
endpackage

//--- core/mem_if.sv
// Write and read port bundle between the translator and a table memory
`timescale 1ns/1ns
interface mem_if #(
  parameter int W = 16,
  parameter int AW = 5
);
  logic wr_en;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [W-1:0] rdata;
  modport ctrl (output wr_en, output waddr, output wdata, output raddr, input rdata);
  modport mem (input wr_en, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- core/table_mem.sv
// Simple dual-port table memory with registered read data
`timescale 1ns/1ns
module table_mem #(
  parameter int W = 16,
  parameter int D = 32
) (
  // Clock
  input wire logic sys_clk_i,
  // Ports
  mem_if.mem port
);
  logic [W-1:0] mem_q [D];
  logic [W-1:0] rdata_q;

  // Read sees the old word on a same-address write
  always_ff @(posedge sys_clk_i) begin
    if (port.wr_en) begin
      mem_q[port.waddr] <= port.wdata;
    end
    rdata_q <= mem_q[port.raddr];
  end

  assign port.rdata = rdata_q;
endmodule // table_mem

//--- core/ecc_check.sv
// SEC-DED check-bit generator and checker for 32-bit table entries
`timescale 1ns/1ns
module ecc_check (
  // Entry
  input wire logic [31:0] data_i,
  input wire logic [6:0] chk_i,
  // Results
  output logic [6:0] gen_o,
  output logic [31:0] data_o,
  output logic ce_o,
  output logic ue_o
);
  // Hamming position of data bit, skipping powers of two
  function automatic logic [5:0] pos_of(input int idx);
    int n;
    logic [5:0] r;
    begin
      n = -1;
      r = 6'h00;
      for (int p = 3; p < 39; p++) begin
        if ((p & (p - 1)) != 0) begin
          n++;
          if (n == idx) begin
            r = p[5:0];
          end
        end
      end
      return r;
    end
  endfunction

  logic [5:0] syn;
  logic par;

  always_comb begin
    gen_o = 7'h00;
    for (int i = 0; i < 32; i++) begin
      gen_o[5:0] = gen_o[5:0] ^ (pos_of(i) & {6{data_i[i]}});
    end
    gen_o[6] = ^{data_i, gen_o[5:0]};
    syn = gen_o[5:0] ^ chk_i[5:0];
    par = ^{data_i, chk_i};
    data_o = data_i;
    for (int i = 0; i < 32; i++) begin
      if (par && syn == pos_of(i)) begin
        data_o[i] = ~data_i[i];
      end
    end
    ce_o = par;
    ue_o = !par && syn != 6'h00;
  end
endmodule // ecc_check

//--- core/bus_adapter_address_translation.sv
// CPU window decode and DMA address translation for the bus adapter
`timescale 1ns/1ns
module bus_adapter_address_translation (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // CPU window command
  input wire logic cpu_valid_i,
  input wire logic [31:0] cpu_cmd_i,
  output logic cpu_claim_o,
  output logic vme_valid_o,
  output logic [31:0] vme_addr_o,
  output logic [1:0] vme_alen_o,
  output logic [1:0] vme_dlen_o,
  // DMA request
  input wire logic dma_valid_i,
  input wire logic [31:0] dma_addr_i,
  output logic dma_ready_o,
  // Host side result
  output logic host_valid_o,
  output logic [39:0] host_physical_address_o,
  output logic dma_abort_o,
  output logic [1:0] abort_cause_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH} dma_st_t;

  // Whole block state; one next-state copy is built each cycle
  typedef struct packed {
    logic [2:0] mode;
    logic [6:0] node;
    logic [4:0] ot_idx;
    logic [15:0] pm_idx;
    logic [6:0] chk_xor;
    logic [31:0] rdata;
    dma_st_t st;
    logic [31:0] dma_addr;
    logic [2:0] dma_mode;
    logic host_valid;
    logic [39:0] host_addr;
    logic abort;
    logic [1:0] cause;
    logic [1:0] last_cause;
    logic [15:0] ce_cnt;
    logic cpu_pend;
    logic [19:0] cpu_low;
    logic vme_valid;
    logic [31:0] vme_addr;
    logic [1:0] alen;
    logic [1:0] dlen;
  } state_t;

  state_t q;
  state_t d;

  // Offset table is tiny; page map holds 64K entries with check bits
  mem_if #(.W(xlat_pkg::OT_W), .AW(5)) ot_port ();
  mem_if #(.W(xlat_pkg::PM_W), .AW(16)) pm_port ();

  logic [6:0] enc_chk;
  logic [31:0] entry;
  logic ecc_ce;
  logic ecc_ue;
  logic [2:0] mode_now;
  logic range_ok;
  logic [15:0] pm_index;
  logic hit;

  // ****************************************
  // Tables and ECC
  // ****************************************
  table_mem #(.W(xlat_pkg::OT_W), .D(xlat_pkg::OT_DEPTH)) u_offset_table (
    .sys_clk_i(sys_clk_i),
    .port(ot_port.mem)
  );

  table_mem #(.W(xlat_pkg::PM_W), .D(xlat_pkg::PM_DEPTH)) u_page_map_table (
    .sys_clk_i(sys_clk_i),
    .port(pm_port.mem)
  );

  // Encoder alone makes check bits on table writes
  ecc_check u_ecc_enc (
    .data_i(reg_wdata_i),
    .chk_i(7'h00),
    .gen_o(enc_chk),
    .data_o(),
    .ce_o(),
    .ue_o()
  );

  // Decoder fixes single flips before the valid bit is tested
  ecc_check u_ecc_dec (
    .data_i(pm_port.rdata[31:0]),
    .chk_i(pm_port.rdata[38:32]),
    .gen_o(),
    .data_o(entry),
    .ce_o(ecc_ce),
    .ue_o(ecc_ue)
  );

  // ****************************************
  // Table write and read ports
  // ****************************************
  assign ot_port.wr_en = reg_wr_i && reg_addr_i == xlat_pkg::OT_DATA_OFS;
  assign ot_port.waddr = q.ot_idx;
  assign ot_port.wdata = reg_wdata_i[15:0];
  assign ot_port.raddr = cpu_cmd_i[xlat_pkg::OT_SEL_LSB +: 5];

  // Check bits are made here; the xor mask lets software plant errors
  assign pm_port.wr_en = reg_wr_i && reg_addr_i == xlat_pkg::PM_DATA_OFS;
  assign pm_port.waddr = q.pm_idx;
  assign pm_port.wdata = {enc_chk ^ q.chk_xor, reg_wdata_i};
  assign pm_port.raddr = pm_index;

  // ****************************************
  // DMA range check and table index
  // ****************************************
  // Index and range come from the live address, so the fetch starts at once
  assign mode_now = q.mode;

  always_comb begin
    range_ok = 1'b0;
    pm_index = dma_addr_i[24:9];
    case (mode_now)
      xlat_pkg::MODE_PASS: begin
        range_ok = dma_addr_i[31:29] == 3'h0;
      end
      xlat_pkg::MODE_P34, xlat_pkg::MODE_P40_512: begin
        range_ok = dma_addr_i[31:25] == 7'h00;
      end
      xlat_pkg::MODE_P40_4K: begin
        range_ok = dma_addr_i[31:28] == 4'h0;
        pm_index = dma_addr_i[27:12];
      end
      xlat_pkg::MODE_P40_8K: begin
        range_ok = dma_addr_i[31:29] == 3'h0;
        pm_index = dma_addr_i[28:13];
      end
      default: begin
        // Undefined mode codes translate nothing
        range_ok = 1'b0;
      end
    endcase
  end

  // Node resets to zero; software sets it before using the window
  assign hit = cpu_valid_i && cpu_cmd_i[31:xlat_pkg::NODE_LSB] == q.node;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    // Pulses default low and stand for one cycle only
    d = q;
    d.rdata = 32'h0000_0000;
    d.host_valid = 1'b0;
    d.abort = 1'b0;
    d.vme_valid = 1'b0;
    d.cpu_pend = 1'b0;

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        xlat_pkg::UTIL_OFS: d.mode = reg_wdata_i[xlat_pkg::MODE_LSB +: 3];
        xlat_pkg::NODE_OFS: d.node = reg_wdata_i[6:0];
        xlat_pkg::OT_IDX_OFS: d.ot_idx = reg_wdata_i[4:0];
        // Data writes step the index so tables load in bursts
        xlat_pkg::OT_DATA_OFS: d.ot_idx = q.ot_idx + 5'h01;
        xlat_pkg::PM_IDX_OFS: d.pm_idx = reg_wdata_i[15:0];
        xlat_pkg::PM_DATA_OFS: d.pm_idx = q.pm_idx + 16'h0001;
        xlat_pkg::ECC_INJ_OFS: d.chk_xor = reg_wdata_i[6:0];
        default: begin
        end
      endcase
    end

    // Register reads, answered in the next cycle only
    if (reg_rd_i) begin
      case (reg_addr_i)
        xlat_pkg::UTIL_OFS: d.rdata[xlat_pkg::MODE_LSB +: 3] = q.mode;
        xlat_pkg::NODE_OFS: d.rdata[6:0] = q.node;
        xlat_pkg::OT_IDX_OFS: d.rdata[4:0] = q.ot_idx;
        xlat_pkg::PM_IDX_OFS: d.rdata[15:0] = q.pm_idx;
        xlat_pkg::ECC_INJ_OFS: d.rdata[6:0] = q.chk_xor;
        xlat_pkg::STATUS_OFS: begin
          d.rdata[1:0] = q.last_cause;
          d.rdata[xlat_pkg::CE_CNT_LSB +: 16] = q.ce_cnt;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    // CPU window: offset word arrives one cycle after the claim
    if (hit) begin
      d.cpu_pend = 1'b1;
      d.cpu_low = cpu_cmd_i[19:0];
    end
    if (q.cpu_pend) begin
      d.vme_valid = 1'b1;
      d.vme_addr = {ot_port.rdata[11:0], q.cpu_low};
      d.alen = ot_port.rdata[13:12];
      d.dlen = ot_port.rdata[15:14];
    end

    // DMA translation
    case (q.st)
      ST_IDLE: begin
        if (dma_valid_i) begin
          d.dma_addr = dma_addr_i;
          d.dma_mode = mode_now;
          // Range failures abort at once, without a table read
          if (!range_ok) begin
            d.abort = 1'b1;
            d.cause = xlat_pkg::CAUSE_RANGE;
            d.last_cause = xlat_pkg::CAUSE_RANGE;
          end else if (mode_now == xlat_pkg::MODE_PASS) begin
            d.host_valid = 1'b1;
            d.host_addr = {11'h000, dma_addr_i[28:0]};
            d.cause = xlat_pkg::CAUSE_NONE;
          end else begin
            d.st = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        d.st = ST_IDLE;
        // Corrected word is used; only the count records the flip
        if (ecc_ce) begin
          d.ce_cnt = q.ce_cnt + 16'h0001;
        end
        // Uncorrectable error outranks an invalid entry
        if (ecc_ue) begin
          d.abort = 1'b1;
          d.cause = xlat_pkg::CAUSE_ECC;
          d.last_cause = xlat_pkg::CAUSE_ECC;
        end else if (!entry[xlat_pkg::ENTRY_VALID_BIT]) begin
          d.abort = 1'b1;
          d.cause = xlat_pkg::CAUSE_INVALID;
          d.last_cause = xlat_pkg::CAUSE_INVALID;
        end else begin
          d.host_valid = 1'b1;
          d.cause = xlat_pkg::CAUSE_NONE;
          case (q.dma_mode)
            xlat_pkg::MODE_P34: begin
              d.host_addr = {6'h00, entry[24:0], q.dma_addr[8:0]};
            end
            xlat_pkg::MODE_P40_512: begin
              d.host_addr = {1'b0, entry[29:0], q.dma_addr[8:0]};
            end
            xlat_pkg::MODE_P40_4K: begin
              d.host_addr = {1'b0, entry[26:0], q.dma_addr[11:0]};
            end
            xlat_pkg::MODE_P40_8K: begin
              // Only 25 frame bits here, so bit 38 stays zero
              d.host_addr = {2'h0, entry[24:0], q.dma_addr[12:0]};
            end
            default: begin
              d.host_addr = 40'h00_0000_0000;
            end
          endcase
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  // Tables keep their contents; software reloads them after reset
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.mode <= xlat_pkg::MODE_RESET;
      q.node <= xlat_pkg::NODE_RESET;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o = q.rdata;
  // Claim is combinational so the host sees it in the command cycle
  assign cpu_claim_o = hit;
  assign vme_valid_o = q.vme_valid;
  assign vme_addr_o = q.vme_addr;
  assign vme_alen_o = q.alen;
  assign vme_dlen_o = q.dlen;
  // Ready drops only while a table entry is being fetched
  assign dma_ready_o = q.st == ST_IDLE;
  assign host_valid_o = q.host_valid;
  assign host_physical_address_o = q.host_addr;
  assign dma_abort_o = q.abort;
  assign abort_cause_o = q.cause;
endmodule // bus_adapter_address_translation

//--- verif/dma_master.sv
// Behavioural DMA master on the far side of the translator
`timescale 1ns/1ns
module dma_master (
  // Clock
  input wire logic clk_i,
  // Request
  input wire logic ready_i,
  output logic valid_o,
  output logic [31:0] addr_o
);
  initial begin
    valid_o = 1'b0;
    addr_o = 32'h0;
  end
  // Held until taken; released lines show the inverse so stale data never matches
  task automatic send(input logic [31:0] a);
    @(posedge clk_i);
    valid_o <= 1'b1;
    addr_o <= a;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    valid_o <= 1'b0;
    addr_o <= ~a;
  endtask
endmodule // dma_master

//--- verif/bus_adapter_address_translation_monitor.sv
// Port checker for the address translation block
`timescale 1ns/1ns
module xlat_monitor (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // CPU window
  input wire logic cpu_valid_i,
  input wire logic [31:0] cpu_cmd_i,
  input wire logic cpu_claim_o,
  input wire logic vme_valid_o,
  input wire logic [31:0] vme_addr_o,
  // DMA
  input wire logic dma_valid_i,
  input wire logic [31:0] dma_addr_i,
  input wire logic dma_ready_o,
  input wire logic host_valid_o,
  input wire logic [39:0] host_physical_address_o,
  input wire logic dma_abort_o,
  input wire logic [1:0] abort_cause_o
);
  logic [6:0] node_q;
  logic [2:0] mode_q;
  logic acc;
  logic rng_ok;
  // Shadow of node and mode as software wrote them
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      node_q <= 7'h00;
      mode_q <= 3'h0;
    end else if (reg_wr_i && reg_addr_i == xlat_pkg::NODE_OFS) begin
      node_q <= reg_wdata_i[6:0];
    end else if (reg_wr_i && reg_addr_i == xlat_pkg::UTIL_OFS) begin
      mode_q <= reg_wdata_i[19:17];
    end
  end
  always_comb begin
    acc = dma_valid_i && dma_ready_o;
    case (mode_q)
      xlat_pkg::MODE_PASS, xlat_pkg::MODE_P40_8K: rng_ok = dma_addr_i[31:29] == 3'h0;
      xlat_pkg::MODE_P40_4K: rng_ok = dma_addr_i[31:28] == 4'h0;
      xlat_pkg::MODE_P34, xlat_pkg::MODE_P40_512: rng_ok = dma_addr_i[31:25] == 7'h00;
      default: rng_ok = 1'b0;
    endcase
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_fetch;
    !dma_ready_o ##1 (host_valid_o || dma_abort_o) && dma_ready_o;
  endsequence
  sequence s_p9_ok;
    acc && rng_ok && (mode_q == 3'h1 || mode_q == 3'h2) ##2 host_valid_o;
  endsequence
  a_claim_node: assert property (cpu_claim_o == (cpu_valid_i && cpu_cmd_i[31:25] == node_q))
    else $error("claim does not follow node match");
  a_vme_low_bits: assert property (cpu_claim_o |-> ##2 vme_valid_o &&
    vme_addr_o[19:0] == $past(cpu_cmd_i[19:0], 2)) else $error("vme address low bits wrong");
  a_no_claim_quiet: assert property (!cpu_claim_o |-> ##2 !vme_valid_o)
    else $error("vme access without claim");
  a_range_abort: assert property (acc && !rng_ok |=> dma_abort_o && !host_valid_o &&
    abort_cause_o == 2'h1) else $error("out of range address not aborted");
  a_pass_map: assert property (acc && rng_ok && mode_q == 3'h0 |=> host_valid_o &&
    host_physical_address_o == {11'h000, $past(dma_addr_i[28:0])}) else $error("pass map wrong");
  a_paged_wait: assert property (acc && rng_ok && mode_q != 3'h0 |=> s_fetch)
    else $error("paged result timing wrong");
  a_page_offset: assert property (s_p9_ok |->
    host_physical_address_o[8:0] == $past(dma_addr_i[8:0], 2)) else $error("page offset wrong");
  a_one_result: assert property (!(host_valid_o && dma_abort_o))
    else $error("host access on aborted transfer");
endmodule // xlat_monitor
bind bus_adapter_address_translation xlat_monitor u_mon (.sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .cpu_valid_i(cpu_valid_i), .cpu_cmd_i(cpu_cmd_i),
  .cpu_claim_o(cpu_claim_o), .vme_valid_o(vme_valid_o), .vme_addr_o(vme_addr_o),
  .dma_valid_i(dma_valid_i), .dma_addr_i(dma_addr_i), .dma_ready_o(dma_ready_o),
  .host_valid_o(host_valid_o), .host_physical_address_o(host_physical_address_o),
  .dma_abort_o(dma_abort_o), .abort_cause_o(abort_cause_o));

//--- verif/tb_bus_adapter_address_translation.sv
// Self-checking bench for the address translation block
`timescale 1ns/1ns
module tb_bus_adapter_address_translation;
  logic sys_clk_i, resetn_i, reg_wr_i, reg_rd_i, cpu_valid_i, dma_valid_i, dma_ready_o;
  logic cpu_claim_o, vme_valid_o, host_valid_o, dma_abort_o;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, cpu_cmd_i, vme_addr_o, dma_addr_i, a;
  logic [1:0] vme_alen_o, vme_dlen_o, abort_cause_o;
  logic [39:0] host_physical_address_o;
  logic [2:0] m;
  int failures, tests_run, cycles, bb;
  localparam logic [31:0] ENT = 32'hb5a5c3e1;
  bus_adapter_address_translation u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cpu_valid_i(cpu_valid_i),
    .cpu_cmd_i(cpu_cmd_i), .cpu_claim_o(cpu_claim_o), .vme_valid_o(vme_valid_o),
    .vme_addr_o(vme_addr_o), .vme_alen_o(vme_alen_o), .vme_dlen_o(vme_dlen_o),
    .dma_valid_i(dma_valid_i), .dma_addr_i(dma_addr_i), .dma_ready_o(dma_ready_o),
    .host_valid_o(host_valid_o), .host_physical_address_o(host_physical_address_o),
    .dma_abort_o(dma_abort_o), .abort_cause_o(abort_cause_o));
  dma_master u_mst (.clk_i(sys_clk_i), .ready_i(dma_ready_o), .valid_o(dma_valid_i),
    .addr_o(dma_addr_i));
  // ********************************
  // Access tasks and checks
  // ********************************
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata_o});
  endtask
  task automatic cpu(input logic [31:0] c, input logic hit, input logic [39:0] v);
    @(posedge sys_clk_i);
    cpu_valid_i <= 1'b1;
    cpu_cmd_i <= c;
    #1 chk("claim", {39'h0, hit}, {39'h0, cpu_claim_o});
    @(posedge sys_clk_i);
    cpu_valid_i <= 1'b0;
    // Offset word is registered, so the result lags the claim by two edges
    @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    chk("vme_valid", {39'h0, hit}, {39'h0, vme_valid_o});
    if (hit) chk("vme", v, {4'h0, vme_dlen_o, vme_alen_o, vme_addr_o});
  endtask
  task automatic dma(input logic [31:0] ad, input logic [1:0] c, input logic [39:0] h, input int l);
    int n;
    u_mst.send(ad);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (!(host_valid_o || dma_abort_o) && n < 4);
    chk("latency", 40'(l), 40'(n));
    chk("abort", {39'h0, c != 2'h0}, {39'h0, dma_abort_o});
    if (c != 2'h0) chk("cause", {38'h0, c}, {38'h0, abort_cause_o});
    else chk("host", h, host_physical_address_o);
  endtask
  function automatic logic [31:0] ad(input logic [2:0] md, input logic [15:0] ix);
    if (md == xlat_pkg::MODE_P40_4K) ad = {4'h0, ix, 12'habc};
    else if (md == xlat_pkg::MODE_P40_8K) ad = {3'h0, ix, 13'h1abc};
    else ad = {7'h00, ix, 9'h1bc};
  endfunction
  function automatic logic [39:0] xl(input logic [2:0] md, input logic [31:0] v);
    if (md == xlat_pkg::MODE_P34) xl = {6'h00, ENT[24:0], v[8:0]};
    else if (md == xlat_pkg::MODE_P40_512) xl = {1'b0, ENT[29:0], v[8:0]};
    else if (md == xlat_pkg::MODE_P40_4K) xl = {1'b0, ENT[26:0], v[11:0]};
    else xl = {2'h0, ENT[24:0], v[12:0]};
  endfunction
  task automatic test_done;
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ********************************
  // Clock, watchdog and sequence
  // ********************************
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      test_done;
    end
  end
  initial begin
    {failures, tests_run, cycles} = '0;
    {resetn_i, reg_wr_i, reg_rd_i, cpu_valid_i} = 4'h0;
    {reg_addr_i, reg_wdata_i, cpu_cmd_i} = '0;
    repeat (4) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(xlat_pkg::UTIL_OFS, 32'h0);
    dma(32'h1fff_fff0, 2'h0, 40'h00_1fff_fff0, 1);
    dma(32'h2000_0000, 2'h1, 40'h0, 1);
    wr(xlat_pkg::NODE_OFS, 32'h2b);
    wr(xlat_pkg::OT_IDX_OFS, 32'h3);
    wr(xlat_pkg::OT_DATA_OFS, 32'h9abc);
    wr(xlat_pkg::OT_DATA_OFS, 32'h4123);
    cpu({7'h2b, 5'h03, 20'h12345}, 1'b1, {8'h09, 12'habc, 20'h12345});
    cpu({7'h2b, 5'h04, 20'h00001}, 1'b1, {8'h04, 12'h123, 20'h00001});
    cpu({7'h2a, 5'h04, 20'h00001}, 1'b0, 40'h0);
    wr(xlat_pkg::PM_IDX_OFS, 32'h0123);
    wr(xlat_pkg::PM_DATA_OFS, ENT);
    wr(xlat_pkg::PM_DATA_OFS, 32'h7fff_ffff);
    wr(xlat_pkg::ECC_INJ_OFS, 32'h1);
    wr(xlat_pkg::PM_DATA_OFS, ENT);
    wr(xlat_pkg::ECC_INJ_OFS, 32'h3);
    wr(xlat_pkg::PM_DATA_OFS, ENT);
    wr(xlat_pkg::ECC_INJ_OFS, 32'h0);
    for (int i = 1; i < 5; i++) begin
      m = 3'(i);
      bb = (m == xlat_pkg::MODE_P40_4K) ? 28 : (m == xlat_pkg::MODE_P40_8K) ? 29 : 25;
      wr(xlat_pkg::UTIL_OFS, {12'h0, m, 17'h0});
      rd(xlat_pkg::UTIL_OFS, {12'h0, m, 17'h0});
      a = ad(m, 16'h0123);
      dma(a, 2'h0, xl(m, a), 2);
      dma(ad(m, 16'h0124), 2'h2, 40'h0, 2);
      dma(ad(m, 16'h0125), 2'h0, xl(m, ad(m, 16'h0125)), 2);
      dma(ad(m, 16'h0126), 2'h3, 40'h0, 2);
      dma(a | (32'h1 << bb), 2'h1, 40'h0, 1);
    end
    rd(xlat_pkg::STATUS_OFS, 32'h0000_0401);
    wr(xlat_pkg::UTIL_OFS, 32'h000a_0000);
    dma(32'h0, 2'h1, 40'h0, 1);
    rd(8'h40, 32'h0);
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(xlat_pkg::UTIL_OFS, 32'h0);
    dma(32'h0abc_def1, 2'h0, 40'h00_0abc_def1, 1);
    test_done;
  end
endmodule // tb_bus_adapter_address_translation
